// File: osc_source_select.sv
// oscillator source select: control, switch-over and shared pin steering
// assumes apb master on clock; clock_input_pin arrives from outside
`timescale 1ns/10ps

// Operation
// - crystal mode: output pin inverts input pin
// - internal/rc: drive quad clock when enabled
// - otherwise release output pin to port
// - internal source frees input pin
// - source field decode, reset internal
// - frequency field decode, 11 reserved
// - clocks keep running in wait mode
// - crystal range selects one amplifier
// - request bit starts switch, reset clears
// - request ignored in bypassed monitor mode
// - engaged status bit read only
// - eight bit trim register read/write
// - trim relative to selected internal frequency
// - two edges, switch, flag, stop internal
// - double clock is quad clock halved
// - clear source and request returns internal
// - external clock mode forces output enable low
module osc_source_select (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clock_input_pin,
  input wire logic internal_source_clock,
  input wire logic monitor_bypass,
  input wire logic wait_mode,
  output logic clock_output_pin,
  output logic clock_output_pin_oe,
  output logic clock_input_pin_is_osc,
  output logic clock_output_pin_is_osc,
  output logic quad_bus_clock,
  output logic double_bus_clock,
  output logic internal_osc_run,
  output logic [2:0] amplifier_enable,
  output logic [1:0] frequency_code,
  output logic [7:0] trim_factor
);

  // ****************************************
  // synchronisers for pin and analog clock inputs
  // ****************************************
  logic [1:0] ext_sync;
  logic [1:0] int_sync;
  logic ext_last;
  logic [1:0] next_ext_sync;
  logic [1:0] next_int_sync;
  logic next_ext_last;

  // only stage 1 is read by logic; stage 0 feeds stage 1 alone
  always_comb begin
    next_ext_sync = {ext_sync[0], clock_input_pin};
    next_int_sync = {int_sync[0], internal_source_clock};
    next_ext_last = ext_sync[1];
  end

  always_ff @(posedge clock) begin
    ext_sync <= next_ext_sync;
    int_sync <= next_int_sync;
    ext_last <= next_ext_last;
  end

  logic ext_rise;
  assign ext_rise = ext_sync[1] & ~ext_last;

  // ****************************************
  // register file
  // ****************************************
  osc_pkg::osc_ctrl_t ctrl;
  osc_pkg::osc_ctrl_t next_ctrl;
  logic [7:0] trim;
  logic [7:0] next_trim;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic engaged;

  // decode used only for pslverr, on both reads and writes
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == osc_pkg::OSC_ADDR_CONTROL) ||
                 (a == osc_pkg::OSC_ADDR_TRIM);
  endfunction

  // one wait state: answer lands one cycle after the access phase starts
  always_comb begin
    next_ctrl = ctrl;
    next_trim = trim;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      next_pslverr = !addr_known(paddr);
      next_prdata = 32'h0000_0000;
      if (paddr == osc_pkg::OSC_ADDR_CONTROL) begin
        next_prdata[osc_pkg::OSC_POS_SOURCE +: 2] = ctrl.source;
        next_prdata[osc_pkg::OSC_POS_FREQ +: 2] = ctrl.freq;
        next_prdata[osc_pkg::OSC_POS_RANGE +: 2] = ctrl.range;
        next_prdata[osc_pkg::OSC_POS_REQUEST] = ctrl.request;
        next_prdata[osc_pkg::OSC_POS_ENGAGED] = engaged;
        next_prdata[osc_pkg::OSC_POS_OUT_EN] = ctrl.out_en;
      end else if (paddr == osc_pkg::OSC_ADDR_TRIM) begin
        next_prdata[7:0] = trim;
      end
    end
    if (psel && penable && pready && pwrite) begin
      if (paddr == osc_pkg::OSC_ADDR_CONTROL) begin
        next_ctrl.source = osc_pkg::osc_source_t'(
          pwdata[osc_pkg::OSC_POS_SOURCE +: 2]);
        if (pwdata[osc_pkg::OSC_POS_FREQ +: 2] !=
            osc_pkg::OSC_FREQ_RESERVED) begin
          next_ctrl.freq = pwdata[osc_pkg::OSC_POS_FREQ +: 2];
        end
        if (pwdata[osc_pkg::OSC_POS_RANGE +: 2] !=
            osc_pkg::OSC_RANGE_RESERVED) begin
          next_ctrl.range = pwdata[osc_pkg::OSC_POS_RANGE +: 2];
        end
        next_ctrl.request = pwdata[osc_pkg::OSC_POS_REQUEST];
        next_ctrl.out_en = pwdata[osc_pkg::OSC_POS_OUT_EN];
      end else if (paddr == osc_pkg::OSC_ADDR_TRIM) begin
        next_trim = pwdata[7:0];
      end
    end
    // enable cannot stay set while the external clock mode is chosen
    if (next_ctrl.source == osc_pkg::OSC_SRC_EXT_CLOCK) begin
      next_ctrl.out_en = 1'b0;
    end
  end

  // write lands on the edge that samples pready high
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl <= '0;
      trim <= osc_pkg::OSC_RESET_TRIM;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      trim <= next_trim;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // switch-over sequencer
  // ****************************************
  osc_pkg::osc_switch_t sw_state;
  osc_pkg::osc_switch_t next_sw_state;
  logic [1:0] edge_count;
  logic [1:0] next_edge_count;
  logic request_live;

  // bypassed monitor mode makes the request invisible
  assign request_live = ctrl.request && !monitor_bypass;

  always_comb begin
    next_sw_state = sw_state;
    next_edge_count = edge_count;
    case (sw_state)
      osc_pkg::OSC_SW_INTERNAL: begin
        next_edge_count = 2'h0;
        if (request_live && ctrl.source != osc_pkg::OSC_SRC_INTERNAL) begin
          next_sw_state = osc_pkg::OSC_SW_WAIT_EDGES;
        end
      end
      osc_pkg::OSC_SW_WAIT_EDGES: begin
        if (!request_live) begin
          next_sw_state = osc_pkg::OSC_SW_INTERNAL;
        end else if (ext_rise) begin
          next_edge_count = edge_count + 2'h1;
          // second rising edge proves the source is alive
          if (edge_count + 2'h1 == osc_pkg::OSC_EDGES_NEEDED) begin
            next_sw_state = osc_pkg::OSC_SW_ENGAGED;
          end
        end
      end
      osc_pkg::OSC_SW_ENGAGED: begin
        // clearing either request or source drops back to internal
        if (!request_live ||
            ctrl.source == osc_pkg::OSC_SRC_INTERNAL) begin
          next_sw_state = osc_pkg::OSC_SW_INTERNAL;
        end
      end
      default: next_sw_state = osc_pkg::OSC_SW_INTERNAL;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sw_state <= osc_pkg::OSC_SW_INTERNAL;
      edge_count <= 2'h0;
    end else begin
      sw_state <= next_sw_state;
      edge_count <= next_edge_count;
    end
  end

  assign engaged = (sw_state == osc_pkg::OSC_SW_ENGAGED);

  // ****************************************
  // clock generation and pin steering
  // ****************************************
  osc_pkg::osc_pins_t pins;
  osc_pkg::osc_pins_t next_pins;
  logic quad;
  logic next_quad;
  logic dbl;
  logic next_dbl;
  logic next_engaged_q;
  logic engaged_q;
  logic next_int_run;
  logic [2:0] next_amp;
  logic quad_last;
  logic next_quad_last;

  // quad clock follows the active source; wait mode has no input here,
  // so nothing can stall it
  always_comb begin
    next_quad = engaged ? ext_sync[1] : int_sync[1];
    next_quad_last = quad;
    next_dbl = dbl;
    if (quad && !quad_last) begin
      next_dbl = ~dbl;
    end
    next_engaged_q = engaged;
    // internal stops only once the flag is already visible
    next_int_run = !(engaged && engaged_q);
    next_amp = 3'h0;
    if (ctrl.source == osc_pkg::OSC_SRC_CRYSTAL) begin
      next_amp[ctrl.range] = 1'b1;
    end
    next_pins = '0;
    next_pins.in_is_osc = (ctrl.source != osc_pkg::OSC_SRC_INTERNAL) ||
                          engaged;
    case (ctrl.source)
      osc_pkg::OSC_SRC_CRYSTAL: begin
        next_pins.out_is_osc = 1'b1;
        next_pins.out_drive = 1'b1;
        next_pins.out_level = ~ext_sync[1];
      end
      osc_pkg::OSC_SRC_INTERNAL, osc_pkg::OSC_SRC_EXT_RC: begin
        next_pins.out_is_osc = ctrl.out_en;
        next_pins.out_drive = ctrl.out_en;
        next_pins.out_level = quad;
      end
      default: next_pins = next_pins;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      quad <= 1'b0;
      quad_last <= 1'b0;
      dbl <= 1'b0;
      engaged_q <= 1'b0;
      internal_osc_run <= 1'b1;
      amplifier_enable <= 3'h0;
      pins <= '0;
      frequency_code <= 2'h0;
      trim_factor <= osc_pkg::OSC_RESET_TRIM;
    end else begin
      quad <= next_quad;
      quad_last <= next_quad_last;
      dbl <= next_dbl;
      engaged_q <= next_engaged_q;
      internal_osc_run <= next_int_run;
      amplifier_enable <= next_amp;
      pins <= next_pins;
      frequency_code <= ctrl.freq;
      trim_factor <= trim;
    end
  end

  // ****************************************
  // outputs straight from flip-flops
  // ****************************************
  assign quad_bus_clock = quad;
  assign double_bus_clock = dbl;
  assign clock_output_pin = pins.out_level;
  assign clock_output_pin_oe = pins.out_drive;
  assign clock_input_pin_is_osc = pins.in_is_osc;
  assign clock_output_pin_is_osc = pins.out_is_osc;

endmodule

// File: osc_pkg.sv
// package for the oscillator source select block
// assumes an apb slave with 32-bit data and one clock of 50 mhz
package osc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OSC_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] OSC_ADDR_TRIM = 8'h04;
  localparam logic [7:0] OSC_RESET_TRIM = 8'h80;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int OSC_POS_SOURCE = 0;
  localparam int OSC_POS_FREQ = 2;
  localparam int OSC_POS_RANGE = 4;
  localparam int OSC_POS_REQUEST = 6;
  localparam int OSC_POS_ENGAGED = 7;
  localparam int OSC_POS_OUT_EN = 8;

  // ****************************************
  // codes and timing
  // ****************************************
  localparam logic [1:0] OSC_FREQ_RESERVED = 2'h3;
  localparam logic [1:0] OSC_RANGE_RESERVED = 2'h3;
  localparam logic [1:0] OSC_EDGES_NEEDED = 2'h2;

  typedef enum logic [1:0] {
    OSC_SRC_INTERNAL = 2'h0,
    OSC_SRC_EXT_CLOCK = 2'h1,
    OSC_SRC_EXT_RC = 2'h2,
    OSC_SRC_CRYSTAL = 2'h3
  } osc_source_t;

  typedef enum logic [1:0] {
    OSC_FREQ_4M0 = 2'h0,
    OSC_FREQ_8M0 = 2'h1,
    OSC_FREQ_12M8 = 2'h2
  } osc_freq_t;

  // switch-over states, gray along the path
  typedef enum logic [1:0] {
    OSC_SW_INTERNAL = 2'h0,
    OSC_SW_WAIT_EDGES = 2'h1,
    OSC_SW_ENGAGED = 2'h3
  } osc_switch_t;

  // control fields carried together
  typedef struct packed {
    logic out_en;
    logic request;
    logic [1:0] range;
    logic [1:0] freq;
    osc_source_t source;
  } osc_ctrl_t;

  // pin controls carried together
  typedef struct packed {
    logic out_drive;
    logic out_level;
    logic out_is_osc;
    logic in_is_osc;
  } osc_pins_t;

endpackage

// File: osc_source_select_checker.sv
// checker for the oscillator source select block
// sees only the top module ports; bound in below
`timescale 1ns/10ps
module osc_source_select_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic clock_input_pin_is_osc,
  input wire logic clock_output_pin_is_osc,
  input wire logic clock_output_pin_oe,
  input wire logic quad_bus_clock,
  input wire logic double_bus_clock,
  input wire logic internal_osc_run,
  input wire logic [2:0] amplifier_enable,
  input wire logic [1:0] frequency_code,
  input wire logic [7:0] trim_factor
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic wr_trim;
  // completed write to the trim word
  assign wr_trim = psel && penable && pwrite && pready && paddr == 8'h04;
  chk_answer_next: assert property ($rose(penable) && psel |=> pready)
    else $error("no answer after access");
  chk_one_amp: assert property ($onehot0(amplifier_enable))
    else $error("more than one amplifier");
  chk_freq_legal: assert property (frequency_code != 2'h3)
    else $error("reserved frequency in use");
  chk_amp_owns_pin: assert property
    (amplifier_enable != 3'h0 |-> clock_output_pin_is_osc)
    else $error("crystal without output pin");
  chk_drive_owned: assert property
    (clock_output_pin_oe |-> clock_output_pin_is_osc)
    else $error("pin driven while released");
  chk_stop_after: assert property
    ($fell(internal_osc_run) |-> $past(clock_input_pin_is_osc, 2))
    else $error("internal stopped without input");
  chk_ext_pin: assert property
    (!internal_osc_run |-> clock_input_pin_is_osc)
    else $error("external run without input pin");
  chk_half_rate: assert property ($changed(double_bus_clock)
    |-> quad_bus_clock || $past(quad_bus_clock))
    else $error("double clock moved without quad");
  chk_trim_cause: assert property ($changed(trim_factor)
    |-> $past(wr_trim) || $past(wr_trim, 2))
    else $error("trim changed without write");
  cover property ($fell(internal_osc_run));
  cover property (amplifier_enable == 3'h4);
  cover property (clock_output_pin_oe);
endmodule
bind osc_source_select osc_source_select_checker
  osc_source_select_checker_inst (.clock, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pready, .clock_input_pin_is_osc,
  .clock_output_pin_is_osc, .clock_output_pin_oe, .quad_bus_clock,
  .double_bus_clock, .internal_osc_run, .amplifier_enable,
  .frequency_code, .trim_factor);

// File: osc_ext_source.sv
// far-side clock sources: external generator and internal oscillator
// assumes 1 ns units; both stand still while not running
`timescale 1ns/10ps
module osc_ext_source #(
  parameter int EXT_HALF = 100,
  parameter int INT_HALF = 80
) (
  input wire logic ext_run,
  input wire logic int_run,
  output logic ext_clk,
  output logic int_clk
);
  // slow edges so the 50 mhz synchronisers see every level
  initial begin
    ext_clk = 1'b0;
    forever begin
      #(EXT_HALF);
      ext_clk = ext_run ? !ext_clk : 1'b0;
    end
  end
  // internal oscillator halts once told to stop
  initial begin
    int_clk = 1'b0;
    forever begin
      #(INT_HALF);
      if (int_run) int_clk = !int_clk;
    end
  end
endmodule

// File: osc_source_select_tb.sv
// self-checking bench for the oscillator source select block
// drives apb and both clock sources; checker bound separately
`timescale 1ns/10ps
module osc_source_select_tb;
  logic clock, rst_b, psel, penable, pwrite, monitor_bypass, wait_mode;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, ext_run, clock_input_pin;
  logic internal_source_clock, clock_output_pin, clock_output_pin_oe;
  logic clock_input_pin_is_osc, clock_output_pin_is_osc;
  logic quad_bus_clock, double_bus_clock, internal_osc_run;
  logic [2:0] amplifier_enable;
  logic [1:0] frequency_code;
  logic [7:0] trim_factor;
  int mismatches, checks_done, cycles;
  osc_source_select osc_source_select_inst (.clock, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .clock_input_pin, .internal_source_clock, .monitor_bypass,
    .wait_mode, .clock_output_pin, .clock_output_pin_oe,
    .clock_input_pin_is_osc, .clock_output_pin_is_osc, .quad_bus_clock,
    .double_bus_clock, .internal_osc_run, .amplifier_enable,
    .frequency_code, .trim_factor);
  osc_ext_source osc_ext_source_inst (.ext_run, .int_run(internal_osc_run),
    .ext_clk(clock_input_pin), .int_clk(internal_source_clock));
  // ****************************************
  // tasks
  // ****************************************
  // one apb transfer; held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task wrap_up;
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // quad must run; double flips one sample after every quad rise
  task t_clocks(input logic pin);
    logic q, d;
    int rises, flips, bad;
    rises = 0;
    flips = 0;
    bad = 0;
    @(posedge clock);
    q = quad_bus_clock;
    d = double_bus_clock;
    // window ends shifted by one so each rise pairs with its flip
    for (int i = 0; i < 64; i++) begin
      @(posedge clock);
      if (i > 0 && double_bus_clock !== d) flips++;
      if (i < 63 && quad_bus_clock === 1'b1 && q === 1'b0) rises++;
      if (clock_output_pin !== q) bad++;
      q = quad_bus_clock;
      d = double_bus_clock;
    end
    chk("quad_runs", 32'h1, 32'(rises > 4));
    chk("half_rate", 32'(rises), 32'(flips));
    if (pin) chk("out_quad", 32'h0, 32'(bad));
  endtask
  task t_reset;
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b0, 8'h00, 32'h0);
    chk("control", 32'h0, rd);
    apb(1'b0, 8'h04, 32'h0);
    chk("trim", 32'h80, rd);
    chk("run", 32'h1, internal_osc_run);
  endtask
  task t_trim;
    apb(1'b1, 8'h04, 32'hFFFFFF5A);
    apb(1'b0, 8'h04, 32'h0);
    chk("trim", 32'h5A, rd);
    chk("trim_port", 32'h5A, trim_factor);
    apb(1'b1, 8'h08, 32'h1);
    chk("slverr", 32'h1, err);
  endtask
  task t_freq;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, 32'(i) << 2);
      apb(1'b0, 8'h00, 32'h0);
      chk("freq", 32'(i < 3 ? i : 2) << 2, rd);
      chk("freq_port", 32'(i < 3 ? i : 2), frequency_code);
    end
  endtask
  task t_crystal;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, 32'h3 | 32'(i) << 4);
      repeat (3) @(posedge clock);
      chk("amp", 32'h1 << (i < 3 ? i : 2), amplifier_enable);
      chk("out_osc", 32'h1, clock_output_pin_is_osc);
      chk("out_inv", 32'h1, clock_output_pin);
      chk("out_drv", 32'h1, clock_output_pin_oe);
    end
  endtask
  task t_outen;
    apb(1'b1, 8'h00, 32'h100);
    repeat (3) @(posedge clock);
    chk("oe_int", 32'h1, clock_output_pin_oe);
    chk("in_free", 32'h0, clock_input_pin_is_osc);
    t_clocks(1'b1);
    apb(1'b1, 8'h00, 32'h101);
    apb(1'b0, 8'h00, 32'h0);
    chk("oe_forced", 32'h1, rd);
    chk("oe_ext", 32'h0, clock_output_pin_oe);
    apb(1'b1, 8'h00, 32'h102);
    repeat (3) @(posedge clock);
    chk("oe_rc", 32'h1, clock_output_pin_oe);
  endtask
  // wait mode held high: clocks must keep running
  task t_switch(input logic byp);
    // let the previous call's clean-up settle before driving again
    @(posedge clock);
    monitor_bypass <= byp;
    wait_mode <= 1'b1;
    ext_run <= 1'b1;
    apb(1'b1, 8'h00, 32'h41);
    for (int i = 0; i < 40; i++) apb(1'b0, 8'h00, 32'h0);
    chk("engaged", byp ? 32'h41 : 32'hC1, rd);
    chk("run", 32'(byp), internal_osc_run);
    t_clocks(1'b0);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("back", 32'h0, rd);
    chk("run_back", 32'h1, internal_osc_run);
    ext_run <= 1'b0;
    monitor_bypass <= 1'b0;
    wait_mode <= 1'b0;
  endtask
  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #10 clock = !clock;
  end
  // ceiling well above the several hundred cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    {rst_b, psel, penable, pwrite, monitor_bypass, wait_mode} = 6'h0;
    {paddr, pwdata, ext_run} = 41'h0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_trim();
    t_freq();
    t_crystal();
    t_outen();
    t_switch(1'b0);
    t_switch(1'b1);
    wrap_up();
  end
endmodule
